// file: bus_ctl_pkg.sv
package bus_ctl_pkg;

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_ERROR_VECTOR = 8'h02;
  localparam logic [4:0] END_STATE_PLAIN = 5'h09;
  localparam logic [4:0] END_STATE_RMW_WRITE = 5'h15;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam logic [4:0] END_STATE_RESET = 5'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ARB_IDLE    = 3'b000,
    ARB_DELAY   = 3'b001,
    ARB_GRANT   = 3'b010,
    ARB_OWNED   = 3'b011,
    ARB_REGRANT = 3'b100
  } arb_state_t;

  typedef enum logic [3:0] {
    BP_IDLE  = 4'b0000,
    BP_S01   = 4'b0001,
    BP_S23   = 4'b0010,
    BP_WAIT  = 4'b0011,
    BP_DATA  = 4'b0100,
    BP_END   = 4'b0101,
    BP_FLOAT = 4'b0110,
    BP_RETRY = 4'b0111,
    BP_EXC   = 4'b1000
  } bus_phase_t;

  localparam arb_state_t ARB_RESET = ARB_IDLE;
  localparam bus_phase_t PHASE_RESET = BP_IDLE;

  typedef struct packed {
    logic write;
    logic rmw;
    logic rmw_write;
    logic [2:0] fc;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cycle_t;

  localparam cycle_t CYCLE_RESET = '0;

  typedef struct packed {
    logic req;
    logic ack;
    logic fault;
    logic stop;
    logic xack;
    logic two_wire;
    logic [15:0] data;
  } pin_in_t;

endpackage

// file: sync_stage.sv
module sync_stage #(
  parameter int WIDTH = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// file: bus_arbitration_error_control.sv
// What this block does
// - Processor yields the bus only after its current cycle completes.
// - Request dropped before any acknowledge: processor keeps the bus.
// - Grant follows synchronisation, held back until strobe if cycle committed.
// - Request during S0 gets grant on second edge after internal grant.
// - Pending request gets grant again before any processor bus cycle.
// - Arbitration inputs are synchronised before use, through two register stages.
// - Arbitration is a state machine driving grant and three-state control.
// - Two-wire mode forces acknowledge low, giving a three-state machine (idle, delay, grant).
// - Three-state control true and strobe negated floats address, data, control.
// - Arbitration state holds while the bus is in S0 or S1.
// - Fault with transfer ack and stop negated is a bus error.
// - Optionally, fault one clock after transfer ack is a late error.
// - Error ends cycle in S9 or S21; buses float while fault held.
// - After fault negates, start bus-error exception using vector entry 2.
// - Fault with stop held ends cycle, floats, reruns it after stop.
// - Read-modify-write cycles are never retried; fault means bus error.
// - Grant is dropped a few clocks after acknowledge is asserted.
module bus_arbitration_error_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core cycle request
  input wire logic cyc_valid,
  output logic cyc_ready,
  input wire bus_ctl_pkg::cycle_t cyc_in,
  input wire logic late_fault_en,
  // Core results
  output logic cyc_done,
  output logic [15:0] rdata,
  output logic exc_req,
  output logic [7:0] exc_vector,
  output logic [4:0] end_state,
  output logic retry_active,
  output logic three_state,
  // Arbitration pins
  input wire logic mastership_request_n,
  input wire logic grant_acknowledge_n,
  input wire logic two_wire_mode,
  output logic mastership_grant_n,
  // Bus termination pins
  input wire logic transfer_ack_n,
  input wire logic bus_fault_in_n,
  input wire logic stop_request_n,
  // Bus drive pins
  output logic address_strobe_n,
  output logic rw_n,
  output logic [2:0] fc_out,
  output logic ctl_oe,
  output logic [23:0] addr_out,
  output logic addr_oe,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in
);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  bus_ctl_pkg::pin_in_t raw;
  bus_ctl_pkg::pin_in_t s;

  assign raw = '{req: ~mastership_request_n, ack: ~grant_acknowledge_n,
                 fault: ~bus_fault_in_n, stop: ~stop_request_n,
                 xack: ~transfer_ack_n, two_wire: two_wire_mode,
                 data: data_in};

  sync_stage #(.WIDTH($bits(bus_ctl_pkg::pin_in_t))) u_sync (
    .clk(clk),
    .rst(rst),
    .d(raw),
    .q(s)
  );

  logic ack_int;
  assign ack_int = s.ack & ~s.two_wire;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bus_ctl_pkg::arb_state_t arb_r;
  bus_ctl_pkg::bus_phase_t phase_r;
  bus_ctl_pkg::cycle_t cyc_r;
  logic prev_s01_r;
  logic retry_r;
  logic fault_seen;
  logic fault_retry;
  logic as_on;
  logic float_bus;
  logic in_s01;

  assign in_s01 = (phase_r == bus_ctl_pkg::BP_S01);
  assign as_on = (phase_r == bus_ctl_pkg::BP_S23) ||
                 (phase_r == bus_ctl_pkg::BP_WAIT) ||
                 (phase_r == bus_ctl_pkg::BP_DATA);

  // ---------------------------------------------------------------
  // Arbitration machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      arb_r <= bus_ctl_pkg::ARB_RESET;
    end else if (!in_s01) begin
      unique case (arb_r)
        bus_ctl_pkg::ARB_IDLE: begin
          if (s.req && !ack_int) begin
            arb_r <= prev_s01_r ? bus_ctl_pkg::ARB_DELAY
                                : bus_ctl_pkg::ARB_GRANT;
          end else if (ack_int) begin
            arb_r <= bus_ctl_pkg::ARB_OWNED;
          end
        end
        bus_ctl_pkg::ARB_DELAY: begin
          arb_r <= s.req ? bus_ctl_pkg::ARB_GRANT : bus_ctl_pkg::ARB_IDLE;
        end
        bus_ctl_pkg::ARB_GRANT: begin
          if (ack_int) begin
            arb_r <= bus_ctl_pkg::ARB_OWNED;
          end else if (!s.req) begin
            arb_r <= bus_ctl_pkg::ARB_IDLE;
          end
        end
        bus_ctl_pkg::ARB_OWNED: begin
          if (ack_int && s.req) begin
            arb_r <= bus_ctl_pkg::ARB_REGRANT;
          end else if (!ack_int) begin
            arb_r <= s.req ? bus_ctl_pkg::ARB_GRANT : bus_ctl_pkg::ARB_IDLE;
          end
        end
        bus_ctl_pkg::ARB_REGRANT: begin
          if (!ack_int) begin
            arb_r <= bus_ctl_pkg::ARB_GRANT;
          end else if (!s.req) begin
            arb_r <= bus_ctl_pkg::ARB_OWNED;
          end
        end
        default: begin
          arb_r <= bus_ctl_pkg::ARB_IDLE;
        end
      endcase
    end
  end

  // A request seen while the cycle was committed gets one extra edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_s01_r <= 1'b0;
    end else begin
      prev_s01_r <= in_s01;
    end
  end

  assign mastership_grant_n = !((arb_r == bus_ctl_pkg::ARB_GRANT) ||
                                (arb_r == bus_ctl_pkg::ARB_REGRANT));
  assign three_state = (arb_r != bus_ctl_pkg::ARB_IDLE) &&
                       (arb_r != bus_ctl_pkg::ARB_DELAY);

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  // New cycles wait while any request is pending or the bus is lent out.
  assign cyc_ready = (phase_r == bus_ctl_pkg::BP_IDLE) &&
                     (arb_r == bus_ctl_pkg::ARB_IDLE) && !s.req;

  assign fault_retry = s.stop && !cyc_r.rmw;
  assign fault_seen = ((phase_r == bus_ctl_pkg::BP_WAIT) && s.fault &&
                       !s.xack) ||
                      ((phase_r == bus_ctl_pkg::BP_DATA) && late_fault_en &&
                       s.fault);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= bus_ctl_pkg::PHASE_RESET;
    end else begin
      unique case (phase_r)
        bus_ctl_pkg::BP_IDLE: begin
          if (cyc_valid && cyc_ready) begin
            phase_r <= bus_ctl_pkg::BP_S01;
          end
        end
        bus_ctl_pkg::BP_S01: phase_r <= bus_ctl_pkg::BP_S23;
        bus_ctl_pkg::BP_S23: phase_r <= bus_ctl_pkg::BP_WAIT;
        bus_ctl_pkg::BP_WAIT: begin
          if (fault_seen) begin
            phase_r <= bus_ctl_pkg::BP_FLOAT;
          end else if (s.xack) begin
            phase_r <= bus_ctl_pkg::BP_DATA;
          end
        end
        bus_ctl_pkg::BP_DATA: begin
          phase_r <= fault_seen ? bus_ctl_pkg::BP_FLOAT
                                : bus_ctl_pkg::BP_END;
        end
        bus_ctl_pkg::BP_END: phase_r <= bus_ctl_pkg::BP_IDLE;
        bus_ctl_pkg::BP_FLOAT: begin
          if (!s.fault) begin
            phase_r <= retry_r ? bus_ctl_pkg::BP_RETRY
                               : bus_ctl_pkg::BP_EXC;
          end
        end
        bus_ctl_pkg::BP_RETRY: begin
          if (!s.stop) begin
            phase_r <= bus_ctl_pkg::BP_S01;
          end
        end
        bus_ctl_pkg::BP_EXC: phase_r <= bus_ctl_pkg::BP_IDLE;
        default: phase_r <= bus_ctl_pkg::BP_IDLE;
      endcase
    end
  end

  // The latched cycle is kept untouched so a retry reruns it exactly.
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_r <= bus_ctl_pkg::CYCLE_RESET;
    end else if (cyc_valid && cyc_ready) begin
      cyc_r <= cyc_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      retry_r <= 1'b0;
      end_state <= bus_ctl_pkg::END_STATE_RESET;
    end else if (fault_seen) begin
      retry_r <= fault_retry;
      end_state <= cyc_r.rmw_write ? bus_ctl_pkg::END_STATE_RMW_WRITE
                                   : bus_ctl_pkg::END_STATE_PLAIN;
    end else if (phase_r == bus_ctl_pkg::BP_S01) begin
      retry_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= bus_ctl_pkg::RDATA_RESET;
    end else if ((phase_r == bus_ctl_pkg::BP_WAIT) && s.xack &&
                 !fault_seen && !cyc_r.write) begin
      rdata <= s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_done <= 1'b0;
      exc_req <= 1'b0;
      exc_vector <= 8'h00;
    end else begin
      cyc_done <= (phase_r == bus_ctl_pkg::BP_DATA) && !fault_seen;
      exc_req <= (phase_r == bus_ctl_pkg::BP_FLOAT) && !s.fault &&
                 !retry_r;
      exc_vector <= bus_ctl_pkg::BUS_ERROR_VECTOR;
    end
  end

  assign retry_active = (phase_r == bus_ctl_pkg::BP_RETRY);

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  assign float_bus = (three_state && !as_on) ||
                     (phase_r == bus_ctl_pkg::BP_FLOAT) ||
                     (phase_r == bus_ctl_pkg::BP_RETRY);

  assign address_strobe_n = !as_on;
  assign rw_n = !(cyc_r.write && (phase_r != bus_ctl_pkg::BP_IDLE));
  assign fc_out = cyc_r.fc;
  assign addr_out = cyc_r.addr;
  assign data_out = cyc_r.wdata;
  assign ctl_oe = !(three_state && !as_on);
  assign addr_oe = !float_bus;
  assign data_oe = !float_bus && cyc_r.write && as_on;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_no_cycle_on_req: assert property (@(posedge clk) disable iff (rst)
    s.req |-> !cyc_ready)
    else $error("cycle offered while a request is pending");

  a_noise_release: assert property (@(posedge clk) disable iff (rst)
    (arb_r == bus_ctl_pkg::ARB_GRANT) && !s.req && !ack_int && !in_s01
    |=> arb_r == bus_ctl_pkg::ARB_IDLE && mastership_grant_n)
    else $error("withdrawn request did not return bus");

  a_grant_prompt: assert property (@(posedge clk) disable iff (rst)
    (arb_r == bus_ctl_pkg::ARB_IDLE) && s.req && !ack_int && !in_s01 &&
    !prev_s01_r |=> !mastership_grant_n)
    else $error("grant not given on next edge");

  a_grant_delayed: assert property (@(posedge clk) disable iff (rst)
    (arb_r == bus_ctl_pkg::ARB_IDLE) && s.req && !ack_int && prev_s01_r &&
    !in_s01 |=> mastership_grant_n ##1 (!mastership_grant_n || !s.req))
    else $error("special case grant timing wrong");

  a_regrant_pending: assert property (@(posedge clk) disable iff (rst)
    (arb_r == bus_ctl_pkg::ARB_OWNED) && ack_int && s.req && !in_s01
    |=> !mastership_grant_n && phase_r == bus_ctl_pkg::BP_IDLE)
    else $error("pending request not granted again");

  a_sync_depth: assert property (@(posedge clk) disable iff (rst)
    $fell(mastership_request_n) ##1 !mastership_request_n |=> s.req)
    else $error("request not valid after two edges");

  a_two_wire_ack: assert property (@(posedge clk) disable iff (rst)
    s.two_wire |-> (arb_r != bus_ctl_pkg::ARB_OWNED) ||
    $past(arb_r) == bus_ctl_pkg::ARB_OWNED)
    else $error("acknowledge used in two-wire mode");

  a_float_bus: assert property (@(posedge clk) disable iff (rst)
    three_state && address_strobe_n |-> !addr_oe && !data_oe && !ctl_oe)
    else $error("bus driven while lent out");

  a_hold_s01: assert property (@(posedge clk) disable iff (rst)
    in_s01 |=> arb_r == $past(arb_r))
    else $error("arbiter moved during S0 or S1");

  a_error_end: assert property (@(posedge clk) disable iff (rst)
    (phase_r == bus_ctl_pkg::BP_WAIT) && s.fault && !s.xack && !s.stop
    |=> phase_r == bus_ctl_pkg::BP_FLOAT && !retry_r && !addr_oe)
    else $error("bus error not recognised");

  a_late_error: assert property (@(posedge clk) disable iff (rst)
    (phase_r == bus_ctl_pkg::BP_DATA) && late_fault_en && s.fault
    |=> phase_r == bus_ctl_pkg::BP_FLOAT && !cyc_done)
    else $error("late bus error missed");

  a_end_state: assert property (@(posedge clk) disable iff (rst)
    phase_r == bus_ctl_pkg::BP_FLOAT |-> end_state ==
    (cyc_r.rmw_write ? 5'h15 : 5'h09) && !data_oe)
    else $error("wrong end state or bus driven");

  a_exc_start: assert property (@(posedge clk) disable iff (rst)
    (phase_r == bus_ctl_pkg::BP_FLOAT) && !s.fault && !retry_r
    |=> exc_req && exc_vector == 8'h02)
    else $error("exception not started");

  a_retry_rerun: assert property (@(posedge clk) disable iff (rst)
    (phase_r == bus_ctl_pkg::BP_RETRY) && !s.stop
    |=> in_s01 && addr_out == $past(addr_out))
    else $error("retry did not rerun same cycle");

  a_rmw_no_retry: assert property (@(posedge clk) disable iff (rst)
    fault_seen && cyc_r.rmw |=> !retry_r)
    else $error("read-modify-write retried");

  a_ack_ungrant: assert property (@(posedge clk) disable iff (rst)
    (arb_r == bus_ctl_pkg::ARB_GRANT) && ack_int && !in_s01
    |=> mastership_grant_n && three_state)
    else $error("grant kept after acknowledge");

  a_reset_idle: assert property (@(posedge clk)
    rst |=> arb_r == bus_ctl_pkg::ARB_IDLE && mastership_grant_n &&
    !three_state)
    else $error("arbiter not idle after reset");

endmodule

// file: bus_partner.sv
module bus_partner (
  // Clock and device bus state
  input wire logic clk,
  input wire logic address_strobe_n,
  input wire logic mastership_grant_n,
  // Bench controls
  input wire logic [1:0] slave_mode,
  input wire logic arm,
  input wire logic [3:0] slave_wait,
  input wire logic [15:0] read_word,
  input wire logic want,
  input wire logic ack_en,
  input wire logic extra_req,
  // Pins toward the device
  output logic mastership_request_n,
  output logic grant_acknowledge_n,
  output logic transfer_ack_n,
  output logic bus_fault_in_n,
  output logic stop_request_n,
  output logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic own_req_n;
  logic used;
  int n;
  int m;

  // ---------------------------------------------------------------
  // Slave and fault source
  // ---------------------------------------------------------------
  // A fault is raised once per change of arm; the rerun is acknowledged.
  assign mastership_request_n = own_req_n & ~extra_req;
  initial begin
    transfer_ack_n = 1'b1;
    bus_fault_in_n = 1'b1;
    stop_request_n = 1'b1;
    data_in = 16'hffff;
    used = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      if (address_strobe_n === 1'b0) begin
        repeat (slave_wait) @(posedge clk);
        #1;
        if (slave_mode[0] != slave_mode[1] && used != arm) begin
          used = arm;
          bus_fault_in_n = 1'b0;
          stop_request_n = slave_mode != 2'h2;
        end else begin
          transfer_ack_n = 1'b0;
          data_in = read_word;
          if (slave_mode == 2'h3 && used != arm) begin
            used = arm;
            @(posedge clk);
            #1 bus_fault_in_n = 1'b0;
          end
          n = 0;
          while (address_strobe_n === 1'b0 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
          end
          transfer_ack_n = 1'b1;
          data_in = ~read_word;
        end
        if (bus_fault_in_n === 1'b0) begin
          repeat (4) @(posedge clk);
          #1 bus_fault_in_n = 1'b1;
          repeat (2) @(posedge clk);
          #1 stop_request_n = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // External master
  // ---------------------------------------------------------------
  initial begin
    own_req_n = 1'b1;
    grant_acknowledge_n = 1'b1;
    forever begin
      @(posedge clk);
      #1;
      if (!ack_en) begin
        own_req_n = !want;
      end else if (want) begin
        own_req_n = 1'b0;
        m = 0;
        while (!(mastership_grant_n === 1'b0 && address_strobe_n === 1'b1
                 && transfer_ack_n === 1'b1) && m < 100) begin
          @(posedge clk);
          #1;
          m++;
        end
        grant_acknowledge_n = 1'b0;
        @(posedge clk);
        #1 own_req_n = 1'b1;
        repeat (12) @(posedge clk);
        #1 grant_acknowledge_n = 1'b1;
        while (want === 1'b1) @(posedge clk);
      end
    end
  end
endmodule

// file: test_bus_arbitration_error_control.sv
module test_bus_arbitration_error_control;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    bus_ctl_pkg::cycle_t cyc;
    logic [1:0] mode;
    logic lf;
    logic [15:0] word;
    logic done;
    logic [4:0] es;
  } row_t;
  logic clk, rst, cyc_valid, cyc_ready, late_fault_en, cyc_done, exc_req;
  bus_ctl_pkg::cycle_t cyc_in;
  logic [15:0] rdata, data_out, data_in, read_word;
  logic [7:0] exc_vector;
  logic [4:0] end_state;
  logic retry_active, three_state, mastership_request_n, grant_acknowledge_n;
  logic two_wire_mode, mastership_grant_n, transfer_ack_n, bus_fault_in_n;
  logic stop_request_n, address_strobe_n, rw_n, ctl_oe, addr_oe, data_oe;
  logic [2:0] fc_out;
  logic [23:0] addr_out;
  logic [1:0] slave_mode;
  logic [3:0] slave_wait;
  logic arm, want, ack_en, extra_req;
  int fail_count, comparisons, cycles;
  row_t rows [10];

  bus_arbitration_error_control uut (.clk, .rst, .cyc_valid, .cyc_ready,
    .cyc_in, .late_fault_en, .cyc_done, .rdata, .exc_req, .exc_vector,
    .end_state, .retry_active, .three_state, .mastership_request_n,
    .grant_acknowledge_n, .two_wire_mode, .mastership_grant_n,
    .transfer_ack_n, .bus_fault_in_n, .stop_request_n, .address_strobe_n,
    .rw_n, .fc_out, .ctl_oe, .addr_out, .addr_oe, .data_out, .data_oe,
    .data_in);
  bus_partner far (.clk, .address_strobe_n, .mastership_grant_n,
    .slave_mode, .arm, .slave_wait, .read_word, .want, .ack_en, .extra_req,
    .mastership_request_n, .grant_acknowledge_n, .transfer_ack_n,
    .bus_fault_in_n, .stop_request_n, .data_in);

  // ---------------------------------------------------------------
  // Clock, timeout and reporting
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 20000) begin
        fail_count++;
        conclude();
      end
    end
  end
  task conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp,
                          input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = mastership_grant_n;
      1: pick = three_state;
      2: pick = grant_acknowledge_n;
      default: pick = cyc_ready;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(s) !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk_bit(pick(s), v, "handshake level");
  endtask
  function automatic row_t mk(input logic [2:0] wmr, input logic [1:0] md,
    input logic lf, input logic dn, input logic [4:0] es, input logic [7:0] k);
    mk.cyc = {wmr, 1'b1, k[1:0], 8'h00, k, 8'h10, 8'ha5, k};
    mk.mode = md;
    mk.lf = lf;
    mk.word = {k, 8'h3c};
    mk.done = dn;
    mk.es = es;
  endfunction

  // ---------------------------------------------------------------
  // One core cycle against the slave model
  // ---------------------------------------------------------------
  task automatic run(input row_t r);
    logic seen_retry, seen_float, fin;
    int k;
    seen_retry = 1'b0;
    seen_float = 1'b0;
    fin = 1'b0;
    slave_mode = r.mode;
    slave_wait = {2'h0, r.word[9:8]};
    late_fault_en = r.lf;
    read_word = r.word;
    arm = ~arm;
    cyc_in = r.cyc;
    cyc_valid = 1'b1;
    k = 0;
    @(negedge clk);
    while (cyc_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    step();
    cyc_valid = 1'b0;
    k = 0;
    while (!fin && k < 300) begin
      @(negedge clk);
      k++;
      if (address_strobe_n === 1'b0) begin
        chk_word(addr_out, r.cyc.addr, "address");
        chk_bit(addr_oe, 1'b1, "address drive");
        chk_bit(rw_n, !r.cyc.write, "direction");
      end
      if (data_oe === 1'b1)
        chk_word({8'h00, data_out}, {8'h00, r.cyc.wdata}, "wdata");
      if (retry_active === 1'b1) seen_retry = 1'b1;
      if (three_state === 1'b1 && address_strobe_n === 1'b1)
        chk_bit(addr_oe, 1'b0, "lent float");
      else if (addr_oe === 1'b0) seen_float = 1'b1;
      fin = cyc_done === 1'b1 || exc_req === 1'b1;
    end
    chk_bit(cyc_done, r.done, "completion");
    chk_bit(seen_retry, r.mode == 2'h2 && !r.cyc.rmw, "retry");
    chk_bit(seen_float, r.mode != 2'h0 && (r.mode != 2'h3 || r.lf),
            "float");
    if (r.done && !r.cyc.write)
      chk_word({8'h00, rdata}, {8'h00, r.word}, "rdata");
    if (!r.done) begin
      chk_word({16'h0, exc_vector}, {16'h0, bus_ctl_pkg::BUS_ERROR_VECTOR},
               "vector");
      chk_word({19'h0, end_state}, {19'h0, r.es}, "end state");
      chk_bit(bus_fault_in_n, 1'b1, "fault at exception");
    end
    repeat (8) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {cyc_valid, late_fault_en, two_wire_mode, arm, want, extra_req} = '0;
    ack_en = 1'b1;
    cyc_in = '0;
    slave_mode = 2'h0;
    slave_wait = 4'h0;
    read_word = 16'h0000;
    fail_count = 0;
    comparisons = 0;
    rows[0] = mk(3'b000, 2'h0, 1'b1, 1'b1, 5'h00, 8'h01);
    rows[1] = mk(3'b100, 2'h0, 1'b0, 1'b1, 5'h00, 8'h02);
    rows[2] = mk(3'b000, 2'h1, 1'b0, 1'b0, 5'h09, 8'h03);
    rows[3] = mk(3'b100, 2'h2, 1'b0, 1'b1, 5'h00, 8'h04);
    rows[4] = mk(3'b000, 2'h2, 1'b0, 1'b1, 5'h00, 8'h05);
    rows[5] = mk(3'b010, 2'h2, 1'b0, 1'b0, 5'h09, 8'h06);
    rows[6] = mk(3'b111, 2'h2, 1'b0, 1'b0, 5'h15, 8'h07);
    rows[7] = mk(3'b111, 2'h1, 1'b0, 1'b0, 5'h15, 8'h08);
    rows[8] = mk(3'b000, 2'h3, 1'b1, 1'b0, 5'h09, 8'h09);
    rows[9] = mk(3'b000, 2'h3, 1'b0, 1'b1, 5'h00, 8'h0a);
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk_bit(mastership_grant_n, 1'b1, "grant after reset");
    chk_bit(three_state, 1'b0, "float after reset");
    for (int i = 0; i < 10; i++) begin
      run(rows[i]);
    end
    // Request in mid-cycle, then a second request waiting behind it.
    fork
      run(rows[0]);
      begin
        repeat (3) step();
        want = 1'b1;
      end
    join
    wait_for(2, 1'b0, 40);
    chk_bit(three_state, 1'b1, "lent out");
    chk_bit(addr_oe | ctl_oe, 1'b0, "floated");
    step();
    extra_req = 1'b1;
    wait_for(0, 1'b1, 8);
    wait_for(0, 1'b0, 8);
    chk_bit(address_strobe_n, 1'b1, "no own cycle");
    step();
    {want, extra_req} = 2'b00;
    wait_for(2, 1'b1, 20);
    wait_for(1, 1'b0, 10);
    wait_for(3, 1'b1, 10);
    // Request that lands while the next cycle is already committed.
    step();
    extra_req = 1'b1;
    step();
    run(rows[0]);
    chk_bit(mastership_grant_n, 1'b0, "late grant");
    extra_req = 1'b0;
    wait_for(0, 1'b1, 10);
    wait_for(3, 1'b1, 10);
    // Request withdrawn without acknowledge.
    step();
    ack_en = 1'b0;
    want = 1'b1;
    wait_for(0, 1'b0, 10);
    step();
    want = 1'b0;
    wait_for(0, 1'b1, 10);
    wait_for(1, 1'b0, 10);
    step();
    run(rows[1]);
    // Two-wire arbitration.
    two_wire_mode = 1'b1;
    want = 1'b1;
    wait_for(0, 1'b0, 10);
    chk_bit(three_state, 1'b1, "two-wire lent");
    step();
    want = 1'b0;
    wait_for(0, 1'b1, 10);
    wait_for(1, 1'b0, 10);
    step();
    two_wire_mode = 1'b0;
    // Reset while the bus is lent out.
    want = 1'b1;
    wait_for(0, 1'b0, 10);
    step();
    rst = 1'b1;
    step();
    chk_bit(mastership_grant_n, 1'b1, "grant in reset");
    chk_bit(three_state, 1'b0, "float in reset");
    want = 1'b0;
    repeat (3) step();
    rst = 1'b0;
    wait_for(3, 1'b1, 10);
    step();
    ack_en = 1'b1;
    run(rows[0]);
    conclude();
  end
endmodule
